/* core/wd_instruction_decode.sv */
// Purpose: decode 14-bit instruction words and pace their instruction cycles
// Assumes: instruction word and pointer status come from logic on ref_clk
// Notes:   one instruction cycle is four ref_clk phases; clk_en freezes all

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - each instruction is one 14-bit word holding opcode and all operands
// - opcodes fall into byte-file, bit-file and literal/control classes
// - every other instruction completes in exactly one instruction cycle
// - direct and accumulator subroutine invoke take two instruction cycles
// - subroutine exit, exit with literal, interrupt exit take two cycles
// - jumps, bit-test skips and decrement/increment skips take two cycles
// - indirect access while pointer targets program memory adds one cycle
// - one instruction cycle is four oscillator cycles
// - file operands are read, modified, then written; read always happens
// - destination bit 0 sends result to accumulator, 1 back to file; decrement/increment skips with 1 write no file
// - file address selects offsets 0x00 to 0x7F of the current bank
// - bit instructions use a 3-bit field to pick one of eight bits
// - general literal format: opcode bits 13 to 8, constant bits 7 to 0
// - pointer number selects one of two pointers or indirect ports
// - two-bit mode picks pre/post increment/decrement of the pointer
// - don't-care bit positions are ignored whatever they hold
module wd_instruction_decode
  import wd_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  input  wire logic [WORD_W-1:0]   instr_word,
  input  wire logic                instr_valid,
  input  wire logic [1:0]          ptr_in_prog_mem,
  output logic                     instr_ready,
  output wd_phase_t                phase,
  output logic                     cycle_start,
  output logic                     instr_busy,
  output logic                     instr_last_cycle,
  output logic                     stall_cycle,
  output wd_dec_t                  dec,
  output logic                     file_rd_strobe,
  output logic                     file_wr_strobe,
  output logic                     acc_wr_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // decode of one word, purely combinational
  function automatic wd_dec_t decode_word(input logic [WORD_W-1:0] w);
    wd_dec_t    d;
    logic [1:0] top;
    top = w[CLS_HI:CLS_LO];
    d = '0;
    d.opcode  = w[13:8];
    d.literal = w[LIT_W-1:0];
    d.faddr   = w[FADDR_W-1:0];
    d.bitpos  = w[BPOS_LO+BITPOS_W-1:BPOS_LO];
    d.ptr_num  = w[PNUM_BIT];
    d.ptr_mode = wd_ptr_mode_t'(w[1:0]);
    d.cls = WD_CLS_NONE;
    unique case (top)
      CLS_BYTE_P: begin
        if (w[13:4] == CTL_PREFIX) begin
          d.cls = WD_CLS_LIT;
          unique case (w[3:0])
            CTL_SUB_EXIT: d.exit = 1'b1;
            CTL_INT_EXIT: d.exit = 1'b1;
            CTL_ACC_CALL: d.invoke = 1'b1;
            CTL_ACC_JUMP: d.flow_change = 1'b1;
            default: d.flow_change = 1'b0;
          endcase
        end else if (w[13:5] == PTR_UPD_PREFIX) begin
          // pointer update moves data through the chosen indirect port
          d.cls        = WD_CLS_LIT;
          d.ptr_update = 1'b1;
          d.indirect   = 1'b1;
          d.dest_file  = w[3];
        end else begin
          d.cls        = WD_CLS_BYTE;
          d.names_file = 1'b1;
          d.dest_file  = w[DEST_BIT];
          d.flow_change = (w[13:8] == OP_DEC_SKIP) ||
                          (w[13:8] == OP_INC_SKIP);
        end
      end
      CLS_BIT_P: begin
        d.cls        = WD_CLS_BIT;
        d.names_file = 1'b1;
        d.dest_file  = 1'b1;
        d.flow_change = (w[11:10] == OP_SKIP_CLR) ||
                        (w[11:10] == OP_SKIP_SET);
      end
      CLS_JUMP_P: begin
        d.cls = WD_CLS_LIT;
        // bit 11 splits invoke from absolute jump
        if (w[11]) begin
          d.flow_change = 1'b1;
        end else begin
          d.invoke = 1'b1;
        end
      end
      CLS_LIT_P: begin
        d.cls = WD_CLS_LIT;
        if (w[11:9] == OP_REL_JUMP) begin
          d.flow_change = 1'b1;
        end
        if (w[11:8] == OP_EXIT_LIT) begin
          d.exit = 1'b1;
        end
      end
    endcase
    if (d.names_file) begin
      // a file operand at either indirect port goes through a pointer
      d.indirect = (d.faddr == IND_PORT0_ADDR) ||
                   (d.faddr == IND_PORT1_ADDR);
      d.ptr_num  = d.faddr[0];
    end
    // bit field is only meaningful for bit ops; left zero elsewhere
    if (d.cls != WD_CLS_BIT) begin
      d.bitpos = '0;
    end
    if (d.cls == WD_CLS_LIT) begin
      d.faddr = '0;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // one-hot bit select, one gate per bit of the file register
  logic [7:0]    mask_w;
  logic [BITPOS_W-1:0] bitpos_w;
  wd_dec_t       dec_w;

  assign dec_w    = decode_word(instr_word);
  assign bitpos_w = dec_w.bitpos;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mask
      assign mask_w[gi] = (dec_w.cls == WD_CLS_BIT) &&
                          (bitpos_w == BITPOS_W'(gi));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // cycle cost of a freshly decoded word
  logic [1:0] cost_w;
  logic       extra_w;

  always_comb begin
    cost_w = COST_ONE;
    if (dec_w.invoke || dec_w.exit || dec_w.flow_change) begin
      cost_w = COST_TWO;
    end
    // pointer into program memory needs a fetch slot of its own
    extra_w = dec_w.indirect && ptr_in_prog_mem[dec_w.ptr_num];
    if (extra_w) begin
      cost_w = cost_w + COST_EXTRA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wd_state_t st_r;
  wd_state_t st_nxt;
  logic      take_w;
  logic      at_q4_w;

  assign at_q4_w = (st_r.phase == WD_Q4);
  // next word is only taken at the end of the last cycle of the current one
  assign instr_ready = at_q4_w && (st_r.cyc_left == CYC_RST);
  assign take_w      = instr_ready && instr_valid && clk_en;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r.phase)
      WD_Q1: st_nxt.phase = WD_Q2;
      WD_Q2: st_nxt.phase = WD_Q3;
      WD_Q3: st_nxt.phase = WD_Q4;
      WD_Q4: st_nxt.phase = WD_Q1;
    endcase
    if (at_q4_w) begin
      st_nxt.first_cyc = 1'b0;
      if (st_r.cyc_left != CYC_RST) begin
        st_nxt.cyc_left = st_r.cyc_left - 2'h1;
      end else if (take_w) begin
        st_nxt.loaded      = 1'b1;
        st_nxt.first_cyc   = 1'b1;
        st_nxt.cyc_left    = cost_w;
        st_nxt.dec         = dec_w;
        st_nxt.dec.bitmask = mask_w;
      end else begin
        // no word offered: the slot runs empty, nothing is decoded
        st_nxt.loaded = 1'b0;
        st_nxt.dec    = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.phase    <= wd_phase_t'(PHASE_RST);
      st_r.cyc_left <= CYC_RST;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign phase            = st_r.phase;
  assign dec              = st_r.dec;
  assign cycle_start      = (st_r.phase == WD_Q1);
  assign instr_busy       = st_r.loaded;
  assign instr_last_cycle = st_r.loaded && (st_r.cyc_left == CYC_RST);
  // every cycle after the first of a loaded instruction counts as a stall cycle
  assign stall_cycle      = st_r.loaded && !st_r.first_cyc;

  // read in Q2 of the first cycle, write in Q4 of the last one
  assign file_rd_strobe = st_r.loaded && st_r.first_cyc && clk_en &&
                          (st_r.dec.names_file || st_r.dec.indirect) &&
                          (st_r.phase == WD_Q2);
  assign file_wr_strobe = instr_last_cycle && at_q4_w && clk_en &&
                          st_r.dec.dest_file &&
                          (st_r.dec.names_file || st_r.dec.indirect) &&
                          !st_r.dec.flow_change;
  assign acc_wr_strobe  = instr_last_cycle && at_q4_w && clk_en &&
                          ((st_r.dec.names_file && !st_r.dec.dest_file) ||
                           st_r.dec.exit);

endmodule

/* core/wd_pkg.sv */
// Purpose: shared constants and types of the 14-bit instruction decoder
// Assumes: one core clock, four clock phases per instruction cycle
// Notes:   opcode patterns are fixed decode constants of the core
package wd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned WORD_W        = 14;
  localparam int unsigned PHASES_PER_IC = 4;
  localparam int unsigned FADDR_W       = 7;
  localparam int unsigned BITPOS_W      = 3;
  localparam int unsigned LIT_W         = 8;

  // field positions
  localparam int unsigned CLS_HI   = 13;
  localparam int unsigned CLS_LO   = 12;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned BPOS_LO  = 7;
  localparam int unsigned PNUM_BIT = 2;

  // opcode patterns
  localparam logic [1:0]  CLS_BYTE_P      = 2'h0;
  localparam logic [1:0]  CLS_BIT_P       = 2'h1;
  localparam logic [1:0]  CLS_JUMP_P      = 2'h2;
  localparam logic [1:0]  CLS_LIT_P       = 2'h3;
  localparam logic [5:0]  OP_DEC_SKIP     = 6'h0B;
  localparam logic [5:0]  OP_INC_SKIP     = 6'h0F;
  localparam logic [1:0]  OP_SKIP_CLR     = 2'h2;
  localparam logic [1:0]  OP_SKIP_SET     = 2'h3;
  localparam logic [3:0]  OP_EXIT_LIT     = 4'h4;
  localparam logic [2:0]  OP_REL_JUMP     = 3'h1;
  localparam logic [9:0]  CTL_PREFIX      = 10'h000;
  localparam logic [3:0]  CTL_SUB_EXIT    = 4'h8;
  localparam logic [3:0]  CTL_INT_EXIT    = 4'h9;
  localparam logic [3:0]  CTL_ACC_CALL    = 4'hA;
  localparam logic [3:0]  CTL_ACC_JUMP    = 4'hB;
  localparam logic [8:0]  PTR_UPD_PREFIX  = 9'h002;
  localparam logic [6:0]  IND_PORT0_ADDR  = 7'h00;
  localparam logic [6:0]  IND_PORT1_ADDR  = 7'h01;

  // cycle costs, counted as instruction cycles minus one
  localparam logic [1:0]  COST_ONE        = 2'h0;
  localparam logic [1:0]  COST_TWO        = 2'h1;
  localparam logic [1:0]  COST_EXTRA      = 2'h1;

  // reset values
  localparam logic [1:0]  PHASE_RST       = 2'h3;
  localparam logic [1:0]  CYC_RST         = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    WD_Q1 = 2'b00,
    WD_Q2 = 2'b01,
    WD_Q3 = 2'b10,
    WD_Q4 = 2'b11
  } wd_phase_t;

  typedef enum logic [1:0] {
    WD_CLS_BYTE = 2'b00,
    WD_CLS_BIT  = 2'b01,
    WD_CLS_LIT  = 2'b10,
    WD_CLS_NONE = 2'b11
  } wd_class_t;

  typedef enum logic [1:0] {
    WD_PTR_PRE_INC  = 2'b00,
    WD_PTR_PRE_DEC  = 2'b01,
    WD_PTR_POST_INC = 2'b10,
    WD_PTR_POST_DEC = 2'b11
  } wd_ptr_mode_t;

  typedef struct packed {
    wd_class_t          cls;
    logic [5:0]         opcode;
    logic               dest_file;
    logic [FADDR_W-1:0] faddr;
    logic [BITPOS_W-1:0] bitpos;
    logic [7:0]         bitmask;
    logic [LIT_W-1:0]   literal;
    logic               ptr_num;
    wd_ptr_mode_t       ptr_mode;
    logic               ptr_update;
    logic               names_file;
    logic               indirect;
    logic               flow_change;
    logic               invoke;
    logic               exit;
  } wd_dec_t;

  typedef struct packed {
    wd_phase_t  phase;
    logic [1:0] cyc_left;
    logic       first_cyc;
    logic       loaded;
    wd_dec_t    dec;
  } wd_state_t;

endpackage

/* bench/wd_dec_assertions.sv */
// Purpose: port-level checks of the instruction decoder
// Assumes: one clock domain, resetn asynchronous and active low
// Notes:   bound into every decoder instance
module wd_dec_assertions
  import wd_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      resetn,
  input wire logic      clk_en,
  input wire logic      instr_valid,
  input wire logic      instr_ready,
  input wire wd_phase_t phase,
  input wire logic      cycle_start,
  input wire logic      instr_busy,
  input wire logic      instr_last_cycle,
  input wire logic      stall_cycle,
  input wire wd_dec_t   dec,
  input wire logic      file_rd_strobe,
  input wire logic      file_wr_strobe,
  input wire logic      acc_wr_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  wire logic long_op = dec.flow_change | dec.invoke | dec.exit;
  sequence s_take;
    instr_ready && instr_valid && clk_en;
  endsequence
  sequence s_first;
    phase == WD_Q1 && instr_busy && cycle_start && !stall_cycle;
  endsequence
  // the release edge itself leaves the state in reset, so it is not a step
  a_phase_steps: assert property (clk_en && resetn |=> 2'(phase - $past(phase)) == 2'h1)
    else $error("phase did not step by one");
  a_ready_at_q4: assert property (instr_ready |-> phase == WD_Q4)
    else $error("ready outside last phase");
  a_take_start: assert property (s_take |=> s_first)
    else $error("taken word did not start a cycle");
  a_hold_dec: assert property (!instr_ready |=> $stable(dec))
    else $error("decoded fields moved mid instruction");
  a_read_q2: assert property (file_rd_strobe |->
    phase == WD_Q2 && (dec.names_file || dec.indirect) && !stall_cycle)
    else $error("file read strobe misplaced");
  a_file_write: assert property (file_wr_strobe |->
    phase == WD_Q4 && instr_last_cycle && dec.dest_file)
    else $error("file write strobe misplaced");
  a_acc_write: assert property (acc_wr_strobe |->
    phase == WD_Q4 && instr_last_cycle && !file_wr_strobe)
    else $error("accumulator write strobe misplaced");
  a_one_cycle: assert property (instr_busy && cycle_start && !long_op && !dec.indirect
    |-> instr_last_cycle)
    else $error("plain instruction took extra cycle");
  a_two_cycle: assert property (s_first ##0 long_op |-> !instr_last_cycle)
    else $error("long instruction ended in one cycle");
  a_ready_last: assert property (instr_busy && !instr_last_cycle |-> !instr_ready)
    else $error("next word accepted too early");
endmodule
bind wd_instruction_decode wd_dec_assertions u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .clk_en(clk_en), .instr_valid(instr_valid), .instr_ready(instr_ready), .phase(phase),
  .cycle_start(cycle_start), .instr_busy(instr_busy), .instr_last_cycle(instr_last_cycle),
  .stall_cycle(stall_cycle), .dec(dec), .file_rd_strobe(file_rd_strobe),
  .file_wr_strobe(file_wr_strobe), .acc_wr_strobe(acc_wr_strobe));

/* bench/tb_top.sv */
// Purpose: self-checking bench of the instruction decoder
// Assumes: words driven at rising edge, outputs sampled at falling edge
// Notes:   skips always cost two cycles, three with a program-memory pointer; no condition input exists
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import wd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, resetn = 0, clk_en = 1, instr_valid = 0, gap = 0;
  logic [13:0] instr_word = 14'h0000, cw, w;
  logic [1:0] ptr_in_prog_mem = 2'h0;
  logic instr_ready, cycle_start, instr_busy, instr_last_cycle, stall_cycle;
  logic file_rd_strobe, file_wr_strobe, acc_wr_strobe;
  wd_phase_t phase;
  wd_dec_t dec;
  int num_errors = 0, n_checks = 0, seed = 83, cycles = 0, ncyc, nrd, nfw, naw;
  logic [15:0] notes[$], cur;
  logic [13:0] dw[] = '{14'h0000, 14'h0008, 14'h0009, 14'h000A, 14'h000B, 14'h0040, 14'h0041,
    14'h0042, 14'h0043, 14'h0044, 14'h0045, 14'h0046, 14'h0047, 14'h0B85, 14'h0F05, 14'h0700,
    14'h0781, 14'h0700, 14'h0781, 14'h077F, 14'h07FF, 14'h1000, 14'h13FF, 14'h1801, 14'h1C01,
    14'h1C00, 14'h2000, 14'h2800, 14'h3200, 14'h34A5, 14'h30A5, 14'h3F5A};
  wd_instruction_decode u_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .instr_word(instr_word), .instr_valid(instr_valid), .ptr_in_prog_mem(ptr_in_prog_mem),
    .instr_ready(instr_ready), .phase(phase), .cycle_start(cycle_start), .instr_busy(instr_busy),
    .instr_last_cycle(instr_last_cycle), .stall_cycle(stall_cycle), .dec(dec),
    .file_rd_strobe(file_rd_strobe), .file_wr_strobe(file_wr_strobe),
    .acc_wr_strobe(acc_wr_strobe));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic fil(logic [13:0] x);
    return (x[13:12] == 2'b00 && x[13:8] != 6'h00) || x[13:12] == 2'b01;
  endfunction
  function automatic logic [1:0] exp_n(logic [13:0] x, logic [1:0] p);
    logic [1:0] n;
    n = 2'h1;
    if (x[13:2] == 12'h002 || (fil(x) && !x[12] && (x[13:8] == 6'h0B || x[13:8] == 6'h0F))
        || (x[13:12] == 2'b01 && x[11]) || x[13:12] == 2'b10
        || (x[13:12] == 2'b11 && (x[11:9] == 3'b001 || x[11:8] == 4'h4))) n = 2'h2;
    // pointer updates go through the indirect port as well
    if ((fil(x) && x[6:1] == 6'h00 && p[x[0]]) || (x[13:5] == 9'h002 && p[x[2]])) n = n + 2'h1;
    return n;
  endfunction
  task automatic send(input logic [13:0] x, input logic [1:0] p);
    int k;
    k = 0;
    instr_word <= x;
    instr_valid <= 1'b1;
    ptr_in_prog_mem <= p;
    do begin
      @(posedge ref_clk);
      k++;
    end while (!(instr_ready === 1'b1 && clk_en === 1'b1) && k < 60);
    notes.push_back({x, exp_n(x, p)});
  endtask
  task automatic idle(input int n);
    instr_valid <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial forever #2 ref_clk = ~ref_clk;
  // ceiling leaves ample room over the thousand or so cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    clk_en <= gap ? ($random(seed) % 3 != 0) : 1'b1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  always @(negedge ref_clk) begin
    if (!resetn) notes.delete();
    else if (clk_en) begin
      if (instr_busy && cycle_start && !stall_cycle) begin
        if (notes.size() == 0) `CHK("notes", 1, 0)
        else cur = notes.pop_front();
        cw = cur[15:2];
        ncyc = 0; nrd = 0; nfw = 0; naw = 0;
        if (fil(cw)) `CHK("faddr", cw[6:0], dec.faddr)
        if (fil(cw) && !cw[12]) begin
          `CHK("opcode", cw[13:8], dec.opcode)
          `CHK("dest", cw[7], dec.dest_file)
          `CHK("bitpos", 3'h0, dec.bitpos)
        end
        if (cw[13:12] == 2'b01) begin
          `CHK("bitpos", cw[9:7], dec.bitpos)
          `CHK("mask", 8'h01 << cw[9:7], dec.bitmask)
        end
        if (cw[13:12] == 2'b11) begin
          `CHK("literal", cw[7:0], dec.literal)
          `CHK("faddr", 7'h00, dec.faddr)
        end
        if (cw[13:5] == 9'h002) begin
          `CHK("ptr_num", cw[2], dec.ptr_num)
          `CHK("ptr_mode", cw[1:0], dec.ptr_mode)
        end
        else `CHK("class", cw[13:12] == 2'b01 ? WD_CLS_BIT : fil(cw) ? WD_CLS_BYTE : WD_CLS_LIT, dec.cls)
        if (fil(cw) && cw[6:1] == 6'h00) `CHK("ptr_num", cw[0], dec.ptr_num)
      end
      if (instr_busy && cycle_start) ncyc++;
      nrd += file_rd_strobe;
      nfw += file_wr_strobe;
      naw += acc_wr_strobe;
      if (instr_busy && instr_last_cycle && phase == WD_Q4) begin
        `CHK("cycles", cur[1:0], 2'(ncyc))
        `CHK("reads", 2'(fil(cw) || cw[13:5] == 9'h002), 2'(nrd))
        if (fil(cw) && !cw[12] && cur[1:0] != 2'h2 && exp_n(cw, 2'h0) == 2'h1) begin
          `CHK("file_wr", 2'(cw[7]), 2'(nfw))
          `CHK("acc_wr", 2'(!cw[7]), 2'(naw))
        end
      end
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (dw[i]) send(dw[i], 2'(i));
    idle(8);
    $display("test directed words done");
    gap <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      w = 14'($random(seed));
      if (w[13:8] == 6'h00) w[8] = 1'b1;
      send(w, 2'($random(seed)));
      if ($random(seed) % 5 == 0) idle(5);
    end
    idle(12);
    gap <= 1'b0;
    $display("test random words done");
    send(14'h2000, 2'h0);
    idle(3);
    resetn <= 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK("phase", WD_Q4, phase)
    `CHK("busy", 1'b0, instr_busy)
    `CHK("ready", 1'b1, instr_ready)
    @(posedge ref_clk);
    resetn <= 1'b1;
    send(14'h3000, 2'h0);
    idle(8);
    $display("test mid reset done");
    summarize();
  end
endmodule
